// ---- shared/pbdg_defines.vh ----
`ifndef PBDG_DEFINES_VH
`define PBDG_DEFINES_VH
// ==========================================
// load port selects
`define PBDG_SEL_DELAY   2'h0
`define PBDG_SEL_PERIOD  2'h1
`define PBDG_SEL_RAM     2'h2
// ==========================================
// reset values, limits and state codes
`define PBDG_CODE_RST    32'h0000_0000
`define PBDG_ONE32       32'h0000_0001
`define PBDG_ZERO32      32'h0000_0000
`define PBDG_DATA_RST    8'h00
`define PBDG_ST_IDLE     2'h0
`define PBDG_ST_DELAY    2'h1
`define PBDG_ST_PERIOD   2'h2
`endif

// ---- verilog/pbdg_top.v ----
`timescale 1ns/1ps
`include "pbdg_defines.vh"
module pbdg_top #(
  parameter AW = 12,
  parameter MEM_AW = 13,
  parameter DW = 8
) (
  input  wire          core_clk_i,
  input  wire          rst_b_i,
  input  wire          ld_we_i,
  input  wire [1:0]    ld_sel_i,
  input  wire [31:0]   ld_data_i,
  input  wire [MEM_AW-1:0] ld_addr_i,
  input  wire          arm_i,
  input  wire          start_i,
  input  wire          rd_en_i,
  output wire          term_cnt_b_o,
  output wire [DW-1:0] burst_data_o,
  output wire          burst_valid_o,
  output wire          burst_active_o,
  output wire          armed_o
);
  // ==========================================
  // state codes and sizes
  localparam [1:0] ST_IDLE   = `PBDG_ST_IDLE;
  localparam [1:0] ST_DELAY  = `PBDG_ST_DELAY;
  localparam [1:0] ST_PERIOD = `PBDG_ST_PERIOD;
  localparam       DEPTH     = 1 << MEM_AW;

  // ==========================================
  // storage
  reg [31:0]   delay_ff;
  reg [31:0]   nxt_delay;
  reg [31:0]   period_ff;
  reg [31:0]   nxt_period;
  reg [31:0]   cnt_ff;
  reg [31:0]   nxt_cnt;
  reg [1:0]    st_ff;
  reg [1:0]    nxt_st;
  reg          armed_ff;
  reg          nxt_armed;
  reg          tc_b_ff;
  reg          nxt_tc_b;
  reg [AW-1:0] addr_ff;
  reg [AW-1:0] nxt_addr;
  reg          run_ff;
  reg          nxt_run;
  reg [DW-1:0] burst_data_ff;
  reg [DW-1:0] nxt_data;
  reg          burst_valid_ff;
  reg          nxt_valid;
  reg          start_m_ff;
  reg          start_s_ff;
  reg          start_d_ff;
  reg [DW-1:0] mem [0:DEPTH-1];

  // ==========================================
  // decoded strobes
  wire          ld_delay;
  wire          ld_period;
  wire          ld_ram;
  wire          start_rise;
  wire          start_take;
  wire          tc_hit;
  wire          burst_go;
  wire          rd_take;
  wire [DW-1:0] rd_word;

  // ==========================================
  // helpers
  // one select decode serves every load target, so the targets cannot drift apart
  function sel_is;
    input [1:0] sel;
    input [1:0] want;
    begin
      sel_is = (sel == want);
    end
  endfunction

  // a code of 0 or 1 ends the interval after one cycle
  function at_term;
    input [31:0] cnt;
    begin
      at_term = (cnt <= `PBDG_ONE32);
    end
  endfunction

  // the delay and the period intervals share one countdown step
  function [31:0] cnt_step;
    input [31:0] cnt;
    input [31:0] reload;
    input        term;
    begin
      if (term)
        cnt_step = reload;
      else
        cnt_step = cnt - `PBDG_ONE32;
    end
  endfunction

  // only the lower part of the memory is ever played
  function [MEM_AW-1:0] mem_index;
    input [AW-1:0] addr;
    begin
      mem_index = {{(MEM_AW-AW){1'b0}}, addr};
    end
  endfunction

  function [AW-1:0] addr_step;
    input [AW-1:0] addr;
    begin
      addr_step = addr + {{(AW-1){1'b0}}, 1'b1};
    end
  endfunction

  // ==========================================
  // start synchroniser
  // start comes from another card: two flops settle it before anything reads it
  always @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      start_m_ff <= 1'b0;
      start_s_ff <= 1'b0;
    end else begin
      start_m_ff <= start_i;
      start_s_ff <= start_m_ff;
    end
  end

  // the delayed copy resets low like the idle pin, so no false edge follows reset
  always @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i)
      start_d_ff <= 1'b0;
    else
      start_d_ff <= start_s_ff;
  end

  assign start_rise = start_s_ff & ~start_d_ff;
  assign start_take = (st_ff == ST_IDLE) & armed_ff & start_rise;

  // ==========================================
  // code loads and pattern memory fill
  assign ld_delay  = ld_we_i & sel_is(ld_sel_i, `PBDG_SEL_DELAY);
  assign ld_period = ld_we_i & sel_is(ld_sel_i, `PBDG_SEL_PERIOD);
  assign ld_ram    = ld_we_i & sel_is(ld_sel_i, `PBDG_SEL_RAM);

  // a period load during a run only takes effect at the next reload; a delay load never does
  always @* begin
    nxt_delay = delay_ff;
    if (ld_delay)
      nxt_delay = ld_data_i;
  end

  always @* begin
    nxt_period = period_ff;
    if (ld_period)
      nxt_period = ld_data_i;
  end

  always @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i)
      delay_ff <= `PBDG_CODE_RST;
    else
      delay_ff <= nxt_delay;
  end

  always @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i)
      period_ff <= `PBDG_CODE_RST;
    else
      period_ff <= nxt_period;
  end

  // no reset here: the memory is filled once and then only read
  always @(posedge core_clk_i) begin
    if (ld_ram)
      mem[ld_addr_i] <= ld_data_i[DW-1:0];
  end

  // ==========================================
  // arming
  // a start that arrives while not armed is dropped
  always @* begin
    nxt_armed = armed_ff;
    if (st_ff == ST_IDLE) begin
      if (arm_i)
        nxt_armed = 1'b1;
      if (start_take)
        nxt_armed = 1'b0;
    end
  end

  always @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i)
      armed_ff <= 1'b0;
    else
      armed_ff <= nxt_armed;
  end

  // ==========================================
  // burst timer
  // once started the timer never returns to idle; only reset stops it
  assign tc_hit   = (st_ff != ST_IDLE) && at_term(cnt_ff);
  assign burst_go = tc_hit;

  always @* begin
    nxt_st  = st_ff;
    nxt_cnt = cnt_ff;
    case (st_ff)
      ST_IDLE: begin
        if (start_take) begin
          nxt_cnt = delay_ff;
          nxt_st  = ST_DELAY;
        end
      end
      ST_DELAY: begin
        nxt_cnt = cnt_step(cnt_ff, period_ff, tc_hit);
        if (tc_hit)
          nxt_st = ST_PERIOD;
      end
      ST_PERIOD: begin
        nxt_cnt = cnt_step(cnt_ff, period_ff, tc_hit);
      end
      default: begin
        nxt_st  = ST_IDLE;
        nxt_cnt = `PBDG_CODE_RST;
      end
    endcase
  end

  // terminal count shows active low for one cycle per interval
  always @* begin
    nxt_tc_b = ~tc_hit;
  end

  always @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      st_ff  <= ST_IDLE;
      cnt_ff <= `PBDG_CODE_RST;
    end else begin
      st_ff  <= nxt_st;
      cnt_ff <= nxt_cnt;
    end
  end

  always @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i)
      tc_b_ff <= 1'b1;
    else
      tc_b_ff <= nxt_tc_b;
  end

  // ==========================================
  // pattern readout
  // a new interval wins over a read, so a late burst restarts at address 0
  assign rd_take = run_ff & rd_en_i & ~burst_go;
  assign rd_word = mem[mem_index(addr_ff)];

  always @* begin
    nxt_addr = addr_ff;
    nxt_run  = run_ff;
    if (burst_go) begin
      nxt_addr = {AW{1'b0}};
      nxt_run  = 1'b1;
    end else if (rd_take) begin
      nxt_addr = addr_step(addr_ff);
      if (&addr_ff)
        nxt_run = 1'b0;
    end
  end

  // outside a burst the data lines stay at zero
  always @* begin
    nxt_valid = 1'b0;
    nxt_data  = `PBDG_DATA_RST;
    if (rd_take) begin
      nxt_valid = 1'b1;
      nxt_data  = rd_word;
    end
  end

  always @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      addr_ff <= {AW{1'b0}};
      run_ff  <= 1'b0;
    end else begin
      addr_ff <= nxt_addr;
      run_ff  <= nxt_run;
    end
  end

  always @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      burst_valid_ff <= 1'b0;
      burst_data_ff  <= `PBDG_DATA_RST;
    end else begin
      burst_valid_ff <= nxt_valid;
      burst_data_ff  <= nxt_data;
    end
  end

  // ==========================================
  // outputs
  assign term_cnt_b_o   = tc_b_ff;
  assign burst_data_o   = burst_data_ff;
  assign burst_valid_o  = burst_valid_ff;
  assign burst_active_o = run_ff;
  assign armed_o        = armed_ff;
endmodule // pbdg_top

// ---- test/pbdg_assertions.sv ----
`timescale 1ns/1ps
// ====================
// port checks for the burst generator
module pbdg_chk (
  input wire       core_clk_i,
  input wire       rst_b_i,
  input wire       rd_en_i,
  input wire       start_i,
  input wire       term_cnt_b_o,
  input wire       burst_valid_o,
  input wire       burst_active_o,
  input wire       armed_o,
  input wire [7:0] burst_data_o
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!rst_b_i);
  tc_opens_burst_a: assert property ($fell(term_cnt_b_o) |-> burst_active_o) else $error("tc");
  idle_data_zero_a: assert property (!burst_valid_o |-> burst_data_o == 8'h00) else $error("idle");
  read_gives_byte_a: assert property (burst_active_o && rd_en_i |=> burst_valid_o == term_cnt_b_o) else $error("rd");
  byte_needs_read_a: assert property (burst_valid_o |-> $past(rd_en_i)) else $error("val");
  stop_on_read_a: assert property ($fell(burst_active_o) |-> $past(rd_en_i)) else $error("stop");
  armed_is_idle_a: assert property (armed_o |-> !burst_active_o) else $error("arm");
  start_clears_a: assert property ($fell(armed_o) |-> $past(start_i, 2)) else $error("go");
  tc_after_start_a: assert property ($fell(term_cnt_b_o) |-> !armed_o) else $error("tc0");
  cover property ($fell(armed_o));
  cover property ($fell(term_cnt_b_o));
  cover property ($fell(burst_active_o));
endmodule // pbdg_chk
bind pbdg_top pbdg_chk u_chk (
  .core_clk_i     (core_clk_i),
  .rst_b_i        (rst_b_i),
  .rd_en_i        (rd_en_i),
  .start_i        (start_i),
  .term_cnt_b_o   (term_cnt_b_o),
  .burst_valid_o  (burst_valid_o),
  .burst_active_o (burst_active_o),
  .armed_o        (armed_o),
  .burst_data_o   (burst_data_o)
);

// ---- test/pbdg_frame_sim.sv ----
`timescale 1ns/1ps
// ====================
// frame simulator start source
module pbdg_frame_sim (
  input  wire core_clk_i,
  input  wire go_i,
  output reg  start_o
);
  initial start_o = 1'b0;
  // driven on the falling card clock edge, held four cycles, long enough for the two-flop sync
  always @(posedge go_i) begin
    @(negedge core_clk_i);
    start_o <= 1'b1;
    repeat (4) @(negedge core_clk_i);
    start_o <= 1'b0;
  end
endmodule // pbdg_frame_sim

// ---- test/test_periodic_burst_data_generator.sv ----
`timescale 1ns/1ps
// ====================
// burst generator bench
module test_periodic_burst_data_generator;
  reg         core_clk_i = 1'b0, rst_b_i = 1'b0, ld_we_i = 1'b0;
  reg         arm_i = 1'b0, rd_en_i = 1'b0, go = 1'b0;
  reg  [1:0]  ld_sel_i = 2'h0;
  reg  [31:0] ld_data_i = 32'h0;
  reg  [12:0] ld_addr_i = 13'h0;
  wire [7:0]  burst_data_o;
  wire        start_i, term_cnt_b_o, burst_valid_o, burst_active_o, armed_o;
  integer     fails = 0, num_checks = 0, n, t, cyc = 0, c1;
  always #2.5 core_clk_i = ~core_clk_i;
  always @(posedge core_clk_i) cyc <= cyc + 1;
  pbdg_top dut (
    .core_clk_i     (core_clk_i),
    .rst_b_i        (rst_b_i),
    .ld_we_i        (ld_we_i),
    .ld_sel_i       (ld_sel_i),
    .ld_data_i      (ld_data_i),
    .ld_addr_i      (ld_addr_i),
    .arm_i          (arm_i),
    .start_i        (start_i),
    .rd_en_i        (rd_en_i),
    .term_cnt_b_o   (term_cnt_b_o),
    .burst_data_o   (burst_data_o),
    .burst_valid_o  (burst_valid_o),
    .burst_active_o (burst_active_o),
    .armed_o        (armed_o)
  );
  pbdg_frame_sim sim (.core_clk_i(core_clk_i), .go_i(go), .start_o(start_i));
  function [7:0] pat(input [11:0] a); pat = a[7:0] ^ a[11:4]; endfunction
  task summarize; begin
    $display("checks %0d fails %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  end endtask
  task chk(input [39:0] nm, input [31:0] e, input [31:0] g); begin
    num_checks = num_checks + 1;
    if (e !== g) begin
      fails = fails + 1;
      $display("unexpected %0s exp %0h got %0h", nm, e, g);
    end
  end endtask
  // strobe stays high across back-to-back writes; caller drops it
  task ld(input [1:0] s, input [12:0] a, input [31:0] d); begin
    ld_we_i = 1'b1; ld_sel_i = s; ld_addr_i = a; ld_data_i = d;
    @(negedge core_clk_i);
  end endtask
  task wtc; begin
    t = 0;
    while (term_cnt_b_o !== 1'b0 && t < 9000) begin @(negedge core_clk_i); t = t + 1; end
  end endtask
  task t_load; begin
    chk("rst", 32'h1, {armed_o, burst_active_o, burst_valid_o, term_cnt_b_o});
    ld(2'h0, 13'h0, 32'h14);
    ld(2'h1, 13'h0, 32'h1388);
    for (n = 0; n < 4096; n = n + 1) ld(2'h2, n[12:0], {24'h0, pat(n[11:0])});
    ld(2'h2, 13'h1000, 32'hff);
    ld_we_i = 1'b0;
    $display("load done");
  end endtask
  task t_delay; begin
    arm_i = 1'b1;
    @(negedge core_clk_i);
    chk("armed", 32'h1, armed_o);
    arm_i = 1'b0; go = 1'b1;
    wtc;
    c1 = cyc;
    chk("delay", 32'h1, t >= 20 && t <= 27);
    chk("act", 32'h1, burst_active_o);
    chk("armed", 32'h0, armed_o);
    @(negedge core_clk_i);
    chk("tcw", 32'h1, term_cnt_b_o);
    $display("delay done");
  end endtask
  task t_burst; begin
    n = 0; rd_en_i = 1'b1;
    repeat (4200) begin
      @(negedge core_clk_i);
      if (burst_valid_o === 1'b1) begin chk("data", pat(n), burst_data_o); n = n + 1; end
    end
    chk("count", 32'h1000, n);
    chk("stop", 32'h0, burst_active_o);
    wtc;
    chk("per", 32'h1388, cyc - c1);
    @(negedge core_clk_i);
    chk("again", {1'b1, pat(0)}, {burst_valid_o, burst_data_o});
    $display("burst done");
  end endtask
  initial begin
    repeat (20) @(negedge core_clk_i);
    rst_b_i = 1'b1;
    @(negedge core_clk_i);
    t_load; t_delay; t_burst;
    summarize;
  end
  initial begin #150000; fails = fails + 1; summarize; end
endmodule // test_periodic_burst_data_generator
